// *** shared/mfa_pkg.sv ***
// Constants, types and decoders shared by the filter, alarm and output stage.
// Assumes one 50 MHz clock domain; widths are fixed at the documented values.
package mfa_pkg;

    // ----------------------------------------------------------------
    // Widths and counts
    // ----------------------------------------------------------------
    localparam int NCH = 5;
    localparam int NMAIN = 2;
    localparam int DW = 24;
    localparam int FRAC = 16;
    localparam int ACCW = DW + FRAC;
    localparam int AW = 16;
    localparam int TAUW = 5;
    localparam int PCTW = 7;
    localparam int PERW = 8;
    localparam int MAPW = 3;

    // ----------------------------------------------------------------
    // Codes and limits
    // ----------------------------------------------------------------
    localparam logic [TAUW-1:0] TAU_NONE = 5'h00;
    localparam logic [TAUW-1:0] TAU_MAX = 5'h11;
    localparam logic [PCTW-1:0] PCT_FULL = 7'h64;
    localparam logic [DW-1:0] STIM_STEP = 24'h028f5c;
    localparam logic [MAPW-1:0] MAP_MAIN1 = 3'h0;
    localparam logic [MAPW-1:0] MAP_LAST = 3'h4;
    localparam logic [DW-1:0] DATA_RST = 24'h000000;
    localparam logic [ACCW-1:0] ACC_RST = 40'h0000000000;
    localparam logic [FRAC-1:0] FRAC_ZERO = 16'h0000;
    localparam logic [PERW-1:0] PER_RST = 8'h00;

    typedef enum logic [1:0]
    {
        MFA_OUT_NONE = 2'h0,
        MFA_OUT_EOC = 2'h1,
        MFA_OUT_ALARM = 2'h3
    } mfa_outmode_type;

    typedef enum logic
    {
        MFA_ST_CLEAR = 1'h0,
        MFA_ST_ALARM = 1'h1
    } mfa_alarm_type;

    // ----------------------------------------------------------------
    // Time-constant code to feedback fraction (value / 65536)
    // ----------------------------------------------------------------
    function automatic logic [AW-1:0] mfa_alpha(input logic [TAUW-1:0] code);
        case (code)
            5'h01: mfa_alpha = 16'h5000;
            5'h02: mfa_alpha = 16'h4000;
            5'h03: mfa_alpha = 16'h3800;
            5'h04: mfa_alpha = 16'h3000;
            5'h05: mfa_alpha = 16'h2800;
            5'h06: mfa_alpha = 16'h2000;
            5'h07: mfa_alpha = 16'h1c00;
            5'h08: mfa_alpha = 16'h1800;
            5'h09: mfa_alpha = 16'h1400;
            5'h0a: mfa_alpha = 16'h1000;
            5'h0b: mfa_alpha = 16'h0e00;
            5'h0c: mfa_alpha = 16'h0c00;
            5'h0d: mfa_alpha = 16'h0a00;
            5'h0e: mfa_alpha = 16'h0800;
            5'h0f: mfa_alpha = 16'h0600;
            5'h10: mfa_alpha = 16'h0400;
            5'h11: mfa_alpha = 16'h0200;
            default: mfa_alpha = 16'h0000;
        endcase
    endfunction

endpackage

// *** shared/mfa_filt_if.sv ***
// Carrier between the top level and one filter channel.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface mfa_filt_if;
    logic in_valid;
    logic [mfa_pkg::DW-1:0] in_data;
    logic enable;
    logic [mfa_pkg::AW-1:0] alpha;
    logic out_valid;
    logic [mfa_pkg::DW-1:0] out_data;

    modport chan
    (
        input in_valid,
        input in_data,
        input enable,
        input alpha,
        output out_valid,
        output out_data
    );

    modport ctl
    (
        output in_valid,
        output in_data,
        output enable,
        output alpha,
        input out_valid,
        input out_data
    );
endinterface

// *** src/mfa_iir.sv ***
// One channel of the recursive low-pass filter and its output buffer word.
// Assumes results arrive as single-cycle strobes from same-clock logic.
`timescale 1ns/100ps
module mfa_iir
(
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Channel carrier
    mfa_filt_if.chan fif
);

    // ----------------------------------------------------------------
    // Datapath
    // ----------------------------------------------------------------
    // A 16-bit fraction below the result keeps small steps from stalling
    logic [mfa_pkg::ACCW-1:0] acc_ff;
    logic primed_ff;
    logic out_valid_ff;
    logic [mfa_pkg::DW-1:0] out_data_ff;
    logic [mfa_pkg::ACCW-1:0] nxt_acc;
    wire logic signed [mfa_pkg::ACCW:0] diff;
    wire logic signed [mfa_pkg::ACCW+mfa_pkg::AW+1:0] prod;
    wire logic [mfa_pkg::ACCW-1:0] step;
    wire logic [mfa_pkg::ACCW-1:0] x_acc;

    assign x_acc = {fif.in_data, mfa_pkg::FRAC_ZERO};
    assign diff = $signed({1'b0, x_acc}) - $signed({1'b0, acc_ff});
    assign prod = diff * $signed({1'b0, fif.alpha});
    assign step = prod[mfa_pkg::ACCW+mfa_pkg::FRAC-1:mfa_pkg::FRAC];
    // First sample after enabling loads the state so there is no ramp from zero
    assign nxt_acc = !fif.enable ? x_acc : (!primed_ff ? x_acc : acc_ff + step);

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            acc_ff <= mfa_pkg::ACC_RST;
            primed_ff <= 1'b0;
            out_valid_ff <= 1'b0;
            out_data_ff <= mfa_pkg::DATA_RST;
        end
        else
        begin
            out_valid_ff <= fif.in_valid;
            if (fif.in_valid)
            begin
                acc_ff <= nxt_acc;
                primed_ff <= fif.enable;
                out_data_ff <= nxt_acc[mfa_pkg::ACCW-1:mfa_pkg::FRAC];
            end
            else if (!fif.enable)
            begin
                primed_ff <= 1'b0;
            end
        end
    end

    assign fif.out_valid = out_valid_ff;
    assign fif.out_data = out_data_ff;

endmodule

// *** src/mfa_top.sv ***
// Result post-processing: per-channel filter, analog-output source select,
// and two conversion-done / threshold-alarm notification pins.
// Assumes all inputs come from logic on the same clock.
// How it works
// - Filter only in continuous mode, else bypass
// - Recursive low-pass with exponential step response
// - Same filter on two main, three temperature
// - Tau code: none or seventeen listed values
// - New tau takes effect only after store
// - Two-rate mode freezes config and bypasses filter
// - Mapping selects analog output source channel
// - Two-rate mode forces analog source main one
// - Fixed percentage stimulus overrides analog level
// - Each pin: none, conversion done or alarm
// - Conversion done after buffer holds corrected result
// - Main one on first pin, two second
// - Conversion done level configurable high or low
// - Single or window mode, hysteresis, persistence, polarity
// - Region above/below or outside/inside thresholds
// - Alarm main one first pin, two second
// - Hysteresis is offset each side of threshold
// - Persistence is eight-bit count up to 255
// - Zero hysteresis or persistence disables it
`timescale 1ns/100ps
module mfa_top
(
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Operating mode
    input wire logic continuous_mode,
    input wire logic two_rate_mode,
    // Results from the correction stage
    input wire logic [mfa_pkg::NCH-1:0] res_valid,
    input wire logic [mfa_pkg::NCH-1:0][mfa_pkg::DW-1:0] res_data,
    // Filter configuration
    input wire logic [mfa_pkg::NCH-1:0][mfa_pkg::TAUW-1:0] tau_cfg,
    input wire logic nvm_store,
    // Analog output source
    input wire logic [mfa_pkg::MAPW-1:0] analog_output_pin_map,
    input wire logic analog_output_pin_stim_en,
    input wire logic [mfa_pkg::PCTW-1:0] analog_output_pin_stim_pct,
    // Notification pin configuration, index 0 first pin
    input wire logic [mfa_pkg::NMAIN-1:0][1:0] pin_mode,
    input wire logic [mfa_pkg::NMAIN-1:0] pin_active_high,
    input wire logic [mfa_pkg::NMAIN-1:0] thr_window,
    input wire logic [mfa_pkg::NMAIN-1:0] region_low,
    input wire logic [mfa_pkg::NMAIN-1:0][mfa_pkg::DW-1:0] hysteresis,
    input wire logic [mfa_pkg::NMAIN-1:0][mfa_pkg::PERW-1:0] persistence,
    input wire logic [mfa_pkg::NMAIN-1:0][mfa_pkg::DW-1:0] lower_limit,
    input wire logic [mfa_pkg::NMAIN-1:0][mfa_pkg::DW-1:0] upper_limit,
    // Output buffer
    output logic [mfa_pkg::NCH-1:0] buf_valid,
    output logic [mfa_pkg::NCH-1:0][mfa_pkg::DW-1:0] buf_data,
    output logic [mfa_pkg::NCH-1:0][mfa_pkg::TAUW-1:0] tau_active,
    // Analog output level and pins
    output logic [mfa_pkg::DW-1:0] analog_output_level,
    output logic first_channel_output_pin,
    output logic second_channel_output_pin
);

    // ----------------------------------------------------------------
    // Filter channels
    // ----------------------------------------------------------------
    logic [mfa_pkg::NCH-1:0][mfa_pkg::TAUW-1:0] tau_act_ff;
    wire logic filt_allowed;
    wire logic tau_load;

    mfa_filt_if fif[mfa_pkg::NCH]();

    assign filt_allowed = continuous_mode && !two_rate_mode;
    // Live settings wait for the store; during two-rate mode they are frozen
    assign tau_load = nvm_store && !two_rate_mode;

    genvar gc;
    generate
        for (gc = 0; gc < mfa_pkg::NCH; gc++)
        begin : g_chan
            wire logic [mfa_pkg::TAUW-1:0] tau_clip;
            assign tau_clip = (tau_cfg[gc] > mfa_pkg::TAU_MAX) ? mfa_pkg::TAU_NONE : tau_cfg[gc];
            always_ff @(posedge clock or negedge arst_n)
            begin
                if (!arst_n)
                    tau_act_ff[gc] <= mfa_pkg::TAU_NONE;
                else if (tau_load)
                    tau_act_ff[gc] <= tau_clip;
            end
            assign fif[gc].in_valid = res_valid[gc];
            assign fif[gc].in_data = res_data[gc];
            assign fif[gc].alpha = mfa_pkg::mfa_alpha(tau_act_ff[gc]);
            assign fif[gc].enable = filt_allowed && (tau_act_ff[gc] != mfa_pkg::TAU_NONE);
            mfa_iir u_iir
            (
                .clock(clock),
                .arst_n(arst_n),
                .fif(fif[gc])
            );
            assign buf_valid[gc] = fif[gc].out_valid;
            assign buf_data[gc] = fif[gc].out_data;
        end
    endgenerate

    assign tau_active = tau_act_ff;

    // ----------------------------------------------------------------
    // Analog output source
    // ----------------------------------------------------------------
    logic [mfa_pkg::DW-1:0] analog_output_pin_ff;
    wire logic [mfa_pkg::MAPW-1:0] analog_output_pin_sel;
    wire logic [mfa_pkg::PCTW-1:0] pct_clip;
    wire logic [mfa_pkg::DW+mfa_pkg::PCTW-1:0] stim_prod;
    wire logic [mfa_pkg::DW-1:0] nxt_analog_output_pin;

    // Out-of-range mapping codes fall back to the first main channel
    assign analog_output_pin_sel = (two_rate_mode || analog_output_pin_map > mfa_pkg::MAP_LAST) ? mfa_pkg::MAP_MAIN1 : analog_output_pin_map;
    assign pct_clip = (analog_output_pin_stim_pct > mfa_pkg::PCT_FULL) ? mfa_pkg::PCT_FULL : analog_output_pin_stim_pct;
    assign stim_prod = pct_clip * mfa_pkg::STIM_STEP;
    assign nxt_analog_output_pin = analog_output_pin_stim_en ? stim_prod[mfa_pkg::DW-1:0] : buf_data[analog_output_pin_sel];

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            analog_output_pin_ff <= mfa_pkg::DATA_RST;
        else
            analog_output_pin_ff <= nxt_analog_output_pin;
    end

    assign analog_output_level = analog_output_pin_ff;

    // ----------------------------------------------------------------
    // Conversion done and alarm per main channel
    // ----------------------------------------------------------------
    logic [mfa_pkg::NMAIN-1:0] pin_ff;
    mfa_pkg::mfa_alarm_type [mfa_pkg::NMAIN-1:0] st_ff;
    logic [mfa_pkg::NMAIN-1:0][mfa_pkg::PERW-1:0] per_cnt_ff;

    genvar gp;
    generate
        for (gp = 0; gp < mfa_pkg::NMAIN; gp++)
        begin : g_pin
            wire logic [mfa_pkg::DW:0] x;
            wire logic [mfa_pkg::DW:0] lo_m;
            wire logic [mfa_pkg::DW:0] lo_p;
            wire logic [mfa_pkg::DW:0] up_m;
            wire logic [mfa_pkg::DW:0] up_p;
            wire logic single_set;
            wire logic single_stay;
            wire logic win_set;
            wire logic win_stay;
            wire logic want;
            wire logic change;
            wire logic [mfa_pkg::PERW:0] cnt_inc;
            wire logic flip;
            wire logic asserted;
            mfa_pkg::mfa_alarm_type nxt_st;

            assign x = {1'b0, buf_data[gp]};
            // Hysteresis widens each threshold by the offset on both sides
            assign lo_m = {1'b0, lower_limit[gp]} - {1'b0, hysteresis[gp]};
            assign lo_p = {1'b0, lower_limit[gp]} + {1'b0, hysteresis[gp]};
            assign up_m = {1'b0, upper_limit[gp]} - {1'b0, hysteresis[gp]};
            assign up_p = {1'b0, upper_limit[gp]} + {1'b0, hysteresis[gp]};
            // Single mode compares against the lower limit only
            assign single_set = region_low[gp] ? (x < lo_m) : (x > lo_p);
            assign single_stay = region_low[gp] ? (x <= lo_p) : (x >= lo_m);
            // Window arithmetic relies on the host keeping limits ordered
            assign win_set = region_low[gp] ? (x > lo_p && x < up_m)
                                            : (x < lo_m || x > up_p);
            assign win_stay = region_low[gp] ? (x >= lo_m && x <= up_p)
                                             : (x <= lo_p || x >= up_m);
            assign want = (st_ff[gp] == mfa_pkg::MFA_ST_ALARM)
                        ? (thr_window[gp] ? win_stay : single_stay)
                        : (thr_window[gp] ? win_set : single_set);
            assign change = want != (st_ff[gp] == mfa_pkg::MFA_ST_ALARM);
            assign cnt_inc = {1'b0, per_cnt_ff[gp]} + 9'h001;
            // A setting of zero or one flips on the first differing result
            assign flip = change && (cnt_inc >= {1'b0, persistence[gp]});

            always_comb
            begin
                nxt_st = st_ff[gp];
                case (st_ff[gp])
                    mfa_pkg::MFA_ST_CLEAR: if (flip) nxt_st = mfa_pkg::MFA_ST_ALARM;
                    mfa_pkg::MFA_ST_ALARM: if (flip) nxt_st = mfa_pkg::MFA_ST_CLEAR;
                    default: nxt_st = mfa_pkg::MFA_ST_CLEAR;
                endcase
            end

            always_ff @(posedge clock or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    st_ff[gp] <= mfa_pkg::MFA_ST_CLEAR;
                    per_cnt_ff[gp] <= mfa_pkg::PER_RST;
                end
                else if (buf_valid[gp])
                begin
                    st_ff[gp] <= nxt_st;
                    per_cnt_ff[gp] <= (change && !flip) ? cnt_inc[mfa_pkg::PERW-1:0]
                                                        : mfa_pkg::PER_RST;
                end
            end

            // Done pulse follows the buffer write by one edge, so the data is already readable
            assign asserted = (pin_mode[gp] == mfa_pkg::MFA_OUT_EOC) ? buf_valid[gp]
                            : (pin_mode[gp] == mfa_pkg::MFA_OUT_ALARM)
                              ? (st_ff[gp] == mfa_pkg::MFA_ST_ALARM) : 1'b0;

            always_ff @(posedge clock or negedge arst_n)
            begin
                if (!arst_n)
                    pin_ff[gp] <= 1'b0;
                else
                    pin_ff[gp] <= asserted ^ !pin_active_high[gp];
            end
        end
    endgenerate

    assign first_channel_output_pin = pin_ff[0];
    assign second_channel_output_pin = pin_ff[1];

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_bypass_outside_cont: assert property (
        res_valid[0] && !continuous_mode |=> buf_valid[0] && buf_data[0] == $past(res_data[0]))
        else $error("filter not bypassed outside continuous mode");

    a_two_rate_bypass: assert property (
        res_valid[1] && two_rate_mode |=> buf_data[1] == $past(res_data[1]))
        else $error("filter active in two-rate mode");

    a_tau_needs_store: assert property (
        !tau_load |=> tau_act_ff == $past(tau_act_ff))
        else $error("time constant changed without a store");

    a_tau_code_range: assert property (
        tau_act_ff[2] <= mfa_pkg::TAU_MAX)
        else $error("time constant code out of range");

    a_two_rate_map: assert property (
        two_rate_mode && !analog_output_pin_stim_en |=> analog_output_level == $past(buf_data[0]))
        else $error("analog source not forced to main channel one");

    a_stim_full: assert property (
        analog_output_pin_stim_en && analog_output_pin_stim_pct == mfa_pkg::PCT_FULL
        |=> analog_output_level == 24'hfffff0)
        else $error("full stimulus level wrong");

    a_eoc_high_pulse: assert property (
        pin_mode[0] == mfa_pkg::MFA_OUT_EOC && pin_active_high[0]
        |=> first_channel_output_pin == $past(buf_valid[0]))
        else $error("first pin done pulse not tied to buffer write");

    a_eoc_low_level: assert property (
        pin_mode[1] == mfa_pkg::MFA_OUT_EOC && !pin_active_high[1] && buf_valid[1]
        |=> !second_channel_output_pin)
        else $error("active-low done pulse not driven low");

    a_none_idle: assert property (
        pin_mode[0] == mfa_pkg::MFA_OUT_NONE |=> first_channel_output_pin == !$past(pin_active_high[0]))
        else $error("unused pin not at inactive level");

    a_alarm_on_sample: assert property (
        st_ff[0] != $past(st_ff[0]) |-> $past(buf_valid[0]))
        else $error("alarm changed without a new result");

    a_two_rate_tau_hold: assert property (
        two_rate_mode |=> tau_act_ff == $past(tau_act_ff))
        else $error("time constant changed in two-rate mode");

    a_map_select: assert property (
        !two_rate_mode && !analog_output_pin_stim_en && analog_output_pin_map <= mfa_pkg::MAP_LAST
        |=> analog_output_level == $past(buf_data[analog_output_pin_map]))
        else $error("analog source does not follow the mapping");

    a_eoc_second_pin: assert property (
        pin_mode[1] == mfa_pkg::MFA_OUT_EOC && pin_active_high[1]
        |=> second_channel_output_pin == $past(buf_valid[1]))
        else $error("second pin done pulse not tied to its channel");

    a_none_second_pin: assert property (
        pin_mode[1] == mfa_pkg::MFA_OUT_NONE
        |=> second_channel_output_pin == !$past(pin_active_high[1]))
        else $error("unused second pin not at inactive level");

    a_alarm_first_pin: assert property (
        pin_mode[0] == mfa_pkg::MFA_OUT_ALARM && pin_active_high[0]
        |=> first_channel_output_pin == ($past(st_ff[0]) == mfa_pkg::MFA_ST_ALARM))
        else $error("first pin does not show the channel one alarm");

    a_alarm_low_pin: assert property (
        pin_mode[1] == mfa_pkg::MFA_OUT_ALARM && !pin_active_high[1]
        |=> second_channel_output_pin == ($past(st_ff[1]) != mfa_pkg::MFA_ST_ALARM))
        else $error("active-low alarm level wrong on second pin");

    a_temp_bypass: assert property (
        res_valid[4] && !continuous_mode |=> buf_data[4] == $past(res_data[4]))
        else $error("temperature channel not bypassed outside continuous mode");

    c_filter_on: cover property (res_valid[0] && fif[0].enable);
    c_alarm_set: cover property (st_ff[0] == mfa_pkg::MFA_ST_CLEAR ##1 st_ff[0] == mfa_pkg::MFA_ST_ALARM);
    c_two_rate: cover property (two_rate_mode && res_valid[0]);
    c_stim: cover property (analog_output_pin_stim_en);

endmodule

// *** test/mfa_host_model.sv ***
// Host model: takes each output buffer word in the cycle its strobe shows.
// Assumes the strobes are one cycle wide on the block's own clock.
`timescale 1ns/100ps
module mfa_host_model
(
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Output buffer of the block
    input wire logic [mfa_pkg::NCH-1:0] buf_valid,
    input wire logic [mfa_pkg::NCH-1:0][mfa_pkg::DW-1:0] buf_data,
    // Words taken by the host
    output logic [mfa_pkg::NCH-1:0] rd_valid_ff,
    output logic [mfa_pkg::NCH-1:0][mfa_pkg::DW-1:0] rd_data_ff
);
    // ----------------------------------------------------------------
    // Read side
    // ----------------------------------------------------------------
    // Taken in the strobe cycle: the word only holds until the next result
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_valid_ff <= '0;
            rd_data_ff <= '0;
        end
        else
        begin
            rd_valid_ff <= buf_valid;
            rd_data_ff <= buf_data;
        end
    end
endmodule

// *** test/tb.sv ***
// Self-checking bench for the filter, analog source and notification pins.
// Assumes the host model and the block share one 50 MHz clock.
`timescale 1ns/100ps
module tb;
    logic clock;
    logic arst_n;
    logic continuous_mode;
    logic two_rate_mode;
    logic [mfa_pkg::NCH-1:0] res_valid;
    logic [mfa_pkg::NCH-1:0][mfa_pkg::DW-1:0] res_data;
    logic [mfa_pkg::NCH-1:0][mfa_pkg::TAUW-1:0] tau_cfg;
    logic nvm_store;
    logic [mfa_pkg::MAPW-1:0] analog_output_pin_map;
    logic analog_output_pin_stim_en;
    logic [mfa_pkg::PCTW-1:0] analog_output_pin_stim_pct;
    logic [mfa_pkg::NMAIN-1:0][1:0] pin_mode;
    logic [mfa_pkg::NMAIN-1:0] pin_active_high;
    logic [mfa_pkg::NMAIN-1:0] thr_window;
    logic [mfa_pkg::NMAIN-1:0] region_low;
    logic [mfa_pkg::NMAIN-1:0][mfa_pkg::DW-1:0] hysteresis;
    logic [mfa_pkg::NMAIN-1:0][mfa_pkg::PERW-1:0] persistence;
    logic [mfa_pkg::NMAIN-1:0][mfa_pkg::DW-1:0] lower_limit;
    logic [mfa_pkg::NMAIN-1:0][mfa_pkg::DW-1:0] upper_limit;
    logic [mfa_pkg::NCH-1:0] buf_valid;
    logic [mfa_pkg::NCH-1:0][mfa_pkg::DW-1:0] buf_data;
    logic [mfa_pkg::NCH-1:0][mfa_pkg::TAUW-1:0] tau_active;
    logic [mfa_pkg::DW-1:0] analog_output_level;
    logic first_channel_output_pin;
    logic second_channel_output_pin;
    logic [1:0] pins;
    logic [mfa_pkg::NCH-1:0] rd_valid;
    logic [mfa_pkg::NCH-1:0][mfa_pkg::DW-1:0] rd_data;
    logic [mfa_pkg::DW-1:0] exp_q[mfa_pkg::NCH][$];
    logic [mfa_pkg::DW-1:0] rnd[mfa_pkg::NCH];
    // Alarm bit per region (above, below, outside, inside) for inputs 50, 150, 250
    logic [3:0][2:0] tbl = {3'b010, 3'b101, 3'b001, 3'b110};
    int xs[8] = '{1005, 1011, 1011, 995, 989, 1000, 989, 989};
    logic [7:0] al = 8'b01111100;
    int mismatches;
    int n_checks;
    int seed;

    assign pins = {second_channel_output_pin, first_channel_output_pin};

    mfa_top dut
    (
        .clock, .arst_n, .continuous_mode, .two_rate_mode, .res_valid, .res_data, .tau_cfg,
        .nvm_store, .analog_output_pin_map, .analog_output_pin_stim_en, .analog_output_pin_stim_pct, .pin_mode, .pin_active_high,
        .thr_window, .region_low, .hysteresis, .persistence, .lower_limit, .upper_limit,
        .buf_valid, .buf_data, .tau_active, .analog_output_level, .first_channel_output_pin,
        .second_channel_output_pin
    );

    mfa_host_model host
    (
        .clock, .arst_n, .buf_valid, .buf_data, .rd_valid_ff(rd_valid), .rd_data_ff(rd_data)
    );

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        if (mismatches == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Inputs always move 1 ns after the edge, so no sampling race
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic send(input int ch, input logic [23:0] x, input logic [23:0] e);
        exp_q[ch].push_back(e);
        res_data[ch] = x;
        res_valid[ch] = 1'b1;
        tick(1);
        res_valid[ch] = 1'b0;
        // An idle edge between strobes, so the valid never drops and rises in one step
        tick(1);
    endtask

    // ----------------------------------------------------------------
    // Clock, watchdog and result watcher
    // ----------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    initial
    begin
        #100000;
        mismatches++;
        complete_run();
    end

    always @(posedge clock)
        for (int i = 0; i < mfa_pkg::NCH; i++)
            if (rd_valid[i] === 1'b1)
            begin
                if (exp_q[i].size() == 0)
                begin
                    mismatches++;
                    $display("ERROR %0t: unexpected result on channel %0d", $time, i);
                end
                else
                    check(32'(rd_data[i]), 32'(exp_q[i].pop_front()));
            end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial
    begin
        seed = 32'h37bae7df;
        arst_n = 1'b0;
        {continuous_mode, two_rate_mode, res_valid, res_data, tau_cfg, nvm_store, analog_output_pin_map,
            analog_output_pin_stim_en, analog_output_pin_stim_pct, pin_mode, pin_active_high, thr_window, region_low,
            hysteresis, persistence, lower_limit, upper_limit} = '0;
        tick(5);
        arst_n = 1'b1;
        continuous_mode = 1'b1;
        tau_cfg = {5{5'h06}};
        tick(1);
        check(32'(tau_active), 32'h0);
        for (int c = 0; c < mfa_pkg::NCH; c++)
        begin
            rnd[c] = 24'($random(seed));
            send(c, rnd[c], rnd[c]);
        end
        nvm_store = 1'b1;
        tick(1);
        nvm_store = 1'b0;
        check(32'(tau_active), 32'({5{5'h06}}));
        for (int c = 0; c < mfa_pkg::NCH; c++)
        begin
            send(c, 24'h000000, 24'h000000);
            send(c, 24'h100000, 24'h020000);
            send(c, 24'h100000, 24'h03c000);
        end
        two_rate_mode = 1'b1;
        tau_cfg = '0;
        analog_output_pin_map = 3'h3;
        nvm_store = 1'b1;
        tick(1);
        nvm_store = 1'b0;
        check(32'(tau_active), 32'({5{5'h06}}));
        for (int c = 0; c < mfa_pkg::NCH; c++)
        begin
            rnd[c] = 24'($random(seed));
            send(c, rnd[c], rnd[c]);
        end
        tick(2);
        check(32'(analog_output_level), 32'(rnd[0]));
        two_rate_mode = 1'b0;
        continuous_mode = 1'b0;
        tau_cfg = {5{5'h1f}};
        nvm_store = 1'b1;
        tick(1);
        nvm_store = 1'b0;
        check(32'(tau_active), 32'h0);
        for (int c = 0; c < mfa_pkg::NCH; c++)
        begin
            analog_output_pin_map = 3'(c);
            rnd[c] = 24'($random(seed));
            send(c, rnd[c], rnd[c]);
            tick(2);
            check(32'(analog_output_level), 32'(rnd[c]));
        end
        analog_output_pin_stim_en = 1'b1;
        analog_output_pin_stim_pct = 7'h32;
        tick(2);
        check(32'(analog_output_level), 32'(7'h32 * mfa_pkg::STIM_STEP));
        analog_output_pin_stim_pct = mfa_pkg::PCT_FULL;
        tick(2);
        check(32'(analog_output_level), 32'(mfa_pkg::PCT_FULL * mfa_pkg::STIM_STEP));
        analog_output_pin_stim_en = 1'b0;
        pin_mode = {2'h1, 2'h1};
        pin_active_high = 2'b01;
        tick(1);
        for (int p = 0; p < mfa_pkg::NMAIN; p++)
        begin
            send(p, rnd[p], rnd[p]);
            check(32'(pins), p == 0 ? 32'h3 : 32'h0);
            tick(1);
            check(32'(pins), 32'h2);
        end
        // Limits kept legal: hysteresis below the threshold
        pin_mode = {2'h1, 2'h3};
        pin_active_high = 2'b11;
        lower_limit[0] = 24'd1000;
        hysteresis[0] = 24'd10;
        persistence[0] = 8'h02;
        repeat (2) send(0, 24'h0, 24'h0);
        tick(2);
        for (int k = 0; k < 8; k++)
        begin
            send(0, 24'(xs[k]), 24'(xs[k]));
            tick(2);
            check(32'(pins[0]), 32'(al[k]));
        end
        pin_mode = {2'h3, 2'h3};
        pin_active_high = 2'b01;
        lower_limit[1] = 24'd100;
        upper_limit[1] = 24'd200;
        for (int m = 0; m < 4; m++)
        begin
            {thr_window[1], region_low[1]} = 2'(m);
            for (int k = 0; k < 3; k++)
            begin
                send(1, 24'(50 + 100 * k), 24'(50 + 100 * k));
                tick(2);
                check(32'(pins[1]), 32'(!tbl[m][k]));
            end
        end
        tick(4);
        for (int c = 0; c < mfa_pkg::NCH; c++)
            check(32'(exp_q[c].size()), 32'h0);
        complete_run();
    end
endmodule
